// ### rtl/ulfc_pkg.sv
// shared constants and types for the line format control block
package ulfc_pkg;

    // register byte offsets
    localparam logic [7:0] ULFC_OFS_DATA      = 8'h00;
    localparam logic [7:0] ULFC_OFS_DIV_HIGH  = 8'h04;
    localparam logic [7:0] ULFC_OFS_LINE_CTRL = 8'h0C;
    localparam logic [7:0] ULFC_OFS_MODEM     = 8'h10;
    localparam logic [7:0] ULFC_OFS_STATUS    = 8'h1C;

    // line_control field positions
    localparam int ULFC_LC_DIV_ACCESS = 7;
    localparam int ULFC_LC_BREAK      = 6;
    localparam int ULFC_LC_EVEN       = 4;
    localparam int ULFC_LC_PAR_EN     = 3;
    localparam int ULFC_LC_STOP       = 2;

    // modem_control field positions and writable bits
    localparam int         ULFC_MC_LOOP = 4;
    localparam int         ULFC_MC_SIR  = 6;
    localparam logic [7:0] ULFC_MC_MASK = 8'h50;

    // transceiver_status field positions
    localparam int ULFC_ST_BUSY     = 0;
    localparam int ULFC_ST_RX_READY = 1;
    localparam int ULFC_ST_PAR_ERR  = 2;
    localparam int ULFC_ST_FRM_ERR  = 3;
    localparam int ULFC_ST_TX_EMPTY = 4;

    // reset values
    localparam logic [7:0]  ULFC_LC_RESET  = 8'h00;
    localparam logic [7:0]  ULFC_MC_RESET  = 8'h00;
    localparam logic [15:0] ULFC_DIV_RESET = 16'h0000;

    // cycle counts in oversample ticks, given as last index; ULFC_IR_TICKS is a tick count, ULFC_LEN_BASE a data bit index
    localparam logic [5:0] ULFC_HALF_LAST   = 6'h07;
    localparam logic [5:0] ULFC_BIT_LAST    = 6'h0F;
    localparam logic [5:0] ULFC_STOP15_LAST = 6'h17;
    localparam logic [5:0] ULFC_STOP2_LAST  = 6'h1F;
    localparam logic [3:0] ULFC_PHASE_LAST  = 4'hF;
    localparam logic [3:0] ULFC_IR_TICKS    = 4'h3;
    localparam logic [2:0] ULFC_LEN_BASE    = 3'h4;

    typedef enum logic [2:0] {
        ULFC_IDLE,
        ULFC_START,
        ULFC_DATA,
        ULFC_PARITY,
        ULFC_STOP
    } ulfc_state_type;

endpackage

// ### rtl/ulfc_tx.sv
// character serializer: start, data, optional parity, stop bits
`timescale 1ns/1ps
module ulfc_tx (
    input  wire logic       clk,        // system clock
    input  wire logic       rst_n,      // sync reset, active low
    input  wire logic       tick,       // oversample tick
    input  wire logic       start,      // begin a character
    input  wire logic [7:0] data,       // character to send
    input  wire logic [1:0] data_len,   // data_length_field
    input  wire logic       parity_en,  // parity_enable_bit
    input  wire logic       even_sel,   // even parity select
    input  wire logic       stop_sel,   // extra stop bits
    output logic            line,       // serial level, idle high
    output logic            busy        // character in progress
);
    import ulfc_pkg::*;

    ulfc_state_type state_reg;
    logic [5:0]     cnt_reg;
    logic [2:0]     idx_reg;
    logic [7:0]     shift_reg;
    logic           par_reg;
    logic [7:0]     masked;
    logic [2:0]     data_last;
    logic [5:0]     stop_last;
    logic [5:0]     cnt_last;
    logic           line_next;

    assign data_last = 3'({1'b0, data_len}) + ULFC_LEN_BASE;
    assign masked    = data & (8'hFF >> (2'h3 - data_len));
    // one, one and a half or two stops
    assign stop_last = !stop_sel ? ULFC_BIT_LAST :
                       (data_len == 2'h0) ? ULFC_STOP15_LAST :
                       ULFC_STOP2_LAST;
    assign cnt_last  = (state_reg == ULFC_STOP) ? stop_last : ULFC_BIT_LAST;
    assign busy      = (state_reg != ULFC_IDLE);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ULFC_IDLE;
            cnt_reg   <= 6'h00;
            idx_reg   <= 3'h0;
            shift_reg <= 8'h00;
            par_reg   <= 1'b0;
        end else begin
            case (state_reg)
                ULFC_IDLE: begin
                    if (start) begin
                        state_reg <= ULFC_START;
                        cnt_reg   <= 6'h00;
                        shift_reg <= masked;
                        par_reg   <= even_sel ? ^masked : ~^masked;
                    end
                end
                default: begin
                    if (tick && cnt_reg != cnt_last) begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end else if (tick) begin
                        cnt_reg <= 6'h00;
                        case (state_reg)
                            ULFC_START: begin
                                state_reg <= ULFC_DATA;
                                idx_reg   <= 3'h0;
                            end
                            ULFC_DATA: begin
                                shift_reg <= shift_reg >> 1;
                                idx_reg   <= idx_reg + 3'h1;
                                if (idx_reg == data_last) begin
                                    state_reg <= parity_en ? ULFC_PARITY
                                                           : ULFC_STOP;
                                end
                            end
                            ULFC_PARITY: state_reg <= ULFC_STOP;
                            default:     state_reg <= ULFC_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    always_comb begin
        case (state_reg)
            ULFC_START:  line_next = 1'b0;
            ULFC_DATA:   line_next = shift_reg[0];
            ULFC_PARITY: line_next = par_reg;
            default:     line_next = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line <= 1'b1;
        end else begin
            line <= line_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_parity_skip: assert property (
        state_reg == ULFC_DATA && tick && cnt_reg == ULFC_BIT_LAST
        && idx_reg == data_last && !parity_en |=> state_reg == ULFC_STOP)
        else $error("parity bit sent while parity disabled");

    a_stop_half: assert property (
        state_reg == ULFC_STOP && stop_sel && data_len == 2'h0
        && tick && cnt_reg == ULFC_STOP15_LAST |=> state_reg == ULFC_IDLE)
        else $error("one and a half stop bits not honoured");

    a_data_count: assert property (
        state_reg == ULFC_DATA && tick && cnt_reg == ULFC_BIT_LAST
        && idx_reg < data_last |=> state_reg == ULFC_DATA)
        else $error("data phase ended before configured length");

endmodule

// ### rtl/ulfc_line_ctrl.sv
// line format control: registers, baud tick, break, loopback, receiver
//
// Contract
// - format fields writable only when not busy
// - divisor access bit maps divisor latches
// - break forces serial output low; in loopback the code holds sout high instead
// - break with infrared pulses infrared output
// - loopback feeds break inward, infrared low
// - parity enable adds and checks parity
// - parity sense selects even or odd
// - stop field gives one, 1.5, two
// - receiver checks only first stop bit
// - data length field sets five to eight
// - reserved line control bits read zero
// - loopback returns output to input internally
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module ulfc_line_ctrl (
    input  wire logic        clk,       // system clock, 100 MHz
    input  wire logic        rst_n,     // sync reset, active low
    input  wire logic [7:0]  addr,      // register byte address
    input  wire logic [31:0] wdata,     // write data
    input  wire logic        wr,        // write strobe
    input  wire logic        rd,        // read strobe
    output logic      [31:0] rdata,     // read data, cycle after rd
    input  wire logic        sin,       // serial input pin
    output logic             sout,      // serial output pin
    output logic             ir_out_n,  // infrared pulse output
    output logic             busy       // transceiver busy
);
    import ulfc_pkg::*;

    logic [7:0]     lc_reg;
    logic [7:0]     mc_reg;
    logic [15:0]    div_reg;
    logic [15:0]    div_cnt_reg;
    logic           tick_reg;
    logic [3:0]     ph_reg;
    logic [7:0]     thr_reg;
    logic           thr_valid_reg;
    logic           sin_meta_reg;
    logic           sin_sync_reg;
    ulfc_state_type rx_state_reg;
    logic [5:0]     rx_cnt_reg;
    logic [2:0]     rx_idx_reg;
    logic [7:0]     rx_shift_reg;
    logic           rx_par_reg;
    logic [7:0]     rbr_reg;
    logic           rx_ready_reg;
    logic           perr_reg;
    logic           ferr_reg;
    logic           tx_line;
    logic           tx_busy;
    logic           tx_start;
    logic           busy_now;
    logic           dlab;
    logic           brk;
    logic           loop;
    logic           sir;
    logic           eff_line;
    logic           rx_in;
    logic           rx_done;
    logic           rx_perr;
    logic [2:0]     rx_last;
    logic           wr_lc;
    logic           wr_data;
    logic           rd_data;
    logic           rd_status;
    logic [31:0]    rdata_next;

    assign dlab      = lc_reg[ULFC_LC_DIV_ACCESS];
    assign brk       = lc_reg[ULFC_LC_BREAK];
    assign loop      = mc_reg[ULFC_MC_LOOP];
    assign sir       = mc_reg[ULFC_MC_SIR];
    assign busy_now  = tx_busy | thr_valid_reg
                     | (rx_state_reg != ULFC_IDLE);
    assign wr_lc     = wr && addr == ULFC_OFS_LINE_CTRL;
    assign wr_data   = wr && addr == ULFC_OFS_DATA && !dlab;
    assign rd_data   = rd && addr == ULFC_OFS_DATA && !dlab;
    assign rd_status = rd && addr == ULFC_OFS_STATUS;

    // line_control: break always, format fields gated
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lc_reg <= ULFC_LC_RESET;
        end else if (wr_lc) begin
            lc_reg[ULFC_LC_BREAK] <= wdata[ULFC_LC_BREAK];
            // busy write leaves fields as they were
            if (!busy_now) begin
                lc_reg[ULFC_LC_DIV_ACCESS] <= wdata[ULFC_LC_DIV_ACCESS];
                lc_reg[ULFC_LC_EVEN:0]     <= wdata[ULFC_LC_EVEN:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mc_reg <= ULFC_MC_RESET;
        end else if (wr && addr == ULFC_OFS_MODEM) begin
            mc_reg <= wdata[7:0] & ULFC_MC_MASK;
        end
    end

    // divisor latches reached through access bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg <= ULFC_DIV_RESET;
        end else if (wr && dlab && addr == ULFC_OFS_DATA) begin
            div_reg[7:0] <= wdata[7:0];
        end else if (wr && dlab && addr == ULFC_OFS_DIV_HIGH) begin
            div_reg[15:8] <= wdata[7:0];
        end
    end

    // oversample tick, stopped while divisor is zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_reg <= 16'h0000;
            tick_reg    <= 1'b0;
        end else if (div_reg == 16'h0000
                     || div_cnt_reg >= div_reg - 16'h0001) begin
            div_cnt_reg <= 16'h0000;
            tick_reg    <= (div_reg != 16'h0000);
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
            tick_reg    <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_reg <= 4'h0;
        end else if (tick_reg) begin
            ph_reg <= ph_reg + 4'h1;
        end
    end

    // transmit holding register; starts on a bit boundary
    assign tx_start = thr_valid_reg && !tx_busy && tick_reg
                    && ph_reg == ULFC_PHASE_LAST;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thr_reg       <= 8'h00;
            thr_valid_reg <= 1'b0;
        end else if (wr_data && !thr_valid_reg) begin
            thr_reg       <= wdata[7:0];
            thr_valid_reg <= 1'b1;
        end else if (tx_start) begin
            thr_valid_reg <= 1'b0;
        end
    end

    ulfc_tx u_tx (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (tick_reg),
        .start     (tx_start),
        .data      (thr_reg),
        .data_len  (lc_reg[1:0]),
        .parity_en (lc_reg[ULFC_LC_PAR_EN]),
        .even_sel  (lc_reg[ULFC_LC_EVEN]),
        .stop_sel  (lc_reg[ULFC_LC_STOP]),
        .line      (tx_line),
        .busy      (tx_busy)
    );

    assign eff_line = tx_line & ~brk;

    // output pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sout     <= 1'b1;
            ir_out_n <= 1'b1;
            busy     <= 1'b0;
        end else begin
            // break spaces the line unless looped back
            sout     <= loop | eff_line;
            // infrared pulse on each spacing bit time
            // infrared output held low in loopback
            ir_out_n <= !loop && !(sir && !eff_line
                                   && ph_reg < ULFC_IR_TICKS);
            busy     <= busy_now;
        end
    end

    // receive path; pin passes two flops first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sin_meta_reg <= 1'b1;
            sin_sync_reg <= 1'b1;
        end else begin
            sin_meta_reg <= sin;
            sin_sync_reg <= sin_meta_reg;
        end
    end

    assign rx_in   = loop ? eff_line : sin_sync_reg;
    assign rx_last = 3'({1'b0, lc_reg[1:0]}) + ULFC_LEN_BASE;
    assign rx_done = rx_state_reg == ULFC_STOP && tick_reg
                   && rx_cnt_reg == ULFC_BIT_LAST;
    // even sense wants an even count of ones
    assign rx_perr = lc_reg[ULFC_LC_PAR_EN]
                   & (^rx_shift_reg ^ rx_par_reg ^ ~lc_reg[ULFC_LC_EVEN]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_state_reg <= ULFC_IDLE;
            rx_cnt_reg   <= 6'h00;
            rx_idx_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_par_reg   <= 1'b0;
        end else if (tick_reg) begin
            case (rx_state_reg)
                ULFC_IDLE: begin
                    rx_cnt_reg <= 6'h00;
                    if (!rx_in) begin
                        rx_state_reg <= ULFC_START;
                    end
                end
                ULFC_START: begin
                    rx_cnt_reg <= rx_cnt_reg + 6'h01;
                    if (rx_cnt_reg == ULFC_HALF_LAST) begin
                        rx_cnt_reg   <= 6'h00;
                        rx_idx_reg   <= 3'h0;
                        rx_shift_reg <= 8'h00;
                        rx_state_reg <= rx_in ? ULFC_IDLE : ULFC_DATA;
                    end
                end
                default: begin
                    rx_cnt_reg <= rx_cnt_reg + 6'h01;
                    if (rx_cnt_reg == ULFC_BIT_LAST) begin
                        rx_cnt_reg <= 6'h00;
                        case (rx_state_reg)
                            ULFC_DATA: begin
                                rx_shift_reg[rx_idx_reg] <= rx_in;
                                rx_idx_reg <= rx_idx_reg + 3'h1;
                                if (rx_idx_reg == rx_last) begin
                                    rx_state_reg <=
                                        lc_reg[ULFC_LC_PAR_EN]
                                        ? ULFC_PARITY : ULFC_STOP;
                                end
                            end
                            ULFC_PARITY: begin
                                rx_par_reg   <= rx_in;
                                rx_state_reg <= ULFC_STOP;
                            end
                            // done after the first stop bit
                            default: rx_state_reg <= ULFC_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // receive flags; a new character wins over a clearing read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rbr_reg      <= 8'h00;
            rx_ready_reg <= 1'b0;
            perr_reg     <= 1'b0;
            ferr_reg     <= 1'b0;
        end else begin
            if (rx_done) begin
                rbr_reg      <= rx_shift_reg;
                rx_ready_reg <= 1'b1;
            end else if (rd_data) begin
                rx_ready_reg <= 1'b0;
            end
            if (rx_done && (rx_perr || !rx_in)) begin
                perr_reg <= perr_reg | rx_perr;
                ferr_reg <= ferr_reg | !rx_in;
            end else if (rd_status) begin
                perr_reg <= 1'b0;
                ferr_reg <= 1'b0;
            end
        end
    end

    // read mux, registered
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (addr)
            ULFC_OFS_DATA:
                rdata_next[7:0] = dlab ? div_reg[7:0] : rbr_reg;
            ULFC_OFS_DIV_HIGH:
                rdata_next[7:0] = dlab ? div_reg[15:8] : 8'h00;
            // bit 5 and upper bits read zero
            ULFC_OFS_LINE_CTRL:
                rdata_next[7:0] = lc_reg & 8'hDF;
            ULFC_OFS_MODEM:
                rdata_next[7:0] = mc_reg;
            ULFC_OFS_STATUS: begin
                rdata_next[ULFC_ST_BUSY]     = busy_now;
                rdata_next[ULFC_ST_RX_READY] = rx_ready_reg;
                rdata_next[ULFC_ST_PAR_ERR]  = perr_reg;
                rdata_next[ULFC_ST_FRM_ERR]  = ferr_reg;
                rdata_next[ULFC_ST_TX_EMPTY] = !thr_valid_reg;
            end
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? rdata_next : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_busy_write;
        wr_lc && busy_now;
    endsequence

    a_locked_hold: assert property (
        s_busy_write |=> lc_reg[7] == $past(lc_reg[7])
                         && lc_reg[4:0] == $past(lc_reg[4:0]))
        else $error("format field changed during busy write");

    a_idle_write: assert property (
        wr_lc && !busy_now |=> lc_reg[7:6] == $past(wdata[7:6])
                               && lc_reg[4:0] == $past(wdata[4:0]))
        else $error("idle write to line control not stored");

    a_divisor_route: assert property (
        rd && dlab && addr == ULFC_OFS_DATA
        |=> rdata == {24'h000000, $past(div_reg[7:0])})
        else $error("divisor low not returned with access bit set");

    a_break_space: assert property (
        brk && !loop [*2] |=> !sout)
        else $error("break did not space the output");

    sequence s_break_ir;
        brk && sir && !loop && tick_reg && ph_reg == 4'h0;
    endsequence

    a_break_pulse: assert property (
        s_break_ir |=> !ir_out_n ##0 (ph_reg == 4'h1) ##1 !ir_out_n)
        else $error("infrared not pulsed during break");

    a_loop_ir_low: assert property (
        loop |=> !ir_out_n && sout)
        else $error("loopback did not hold pins");

    a_rsvd_zero: assert property (
        rd && addr == ULFC_OFS_LINE_CTRL
        |=> rdata[31:8] == 24'h000000 && !rdata[5])
        else $error("reserved line control bits read nonzero");

    a_first_stop: assert property (
        rx_done |=> rx_state_reg == ULFC_IDLE && rx_ready_reg)
        else $error("receiver waited past first stop bit");

endmodule

// ### testbench/ulfc_remote_model.sv
// remote serial device model on the transmit and receive lines
`timescale 1ns/1ps
module ulfc_remote_model (
    input  wire logic clk,   // system clock, one tick per cycle
    input  wire logic sout,  // line from the block
    output logic      sin    // line into the block, idle marking
);
    initial sin = 1'b1;

    // sample each bit mid-way, least significant first
    task automatic grab(input int nbits, output logic [9:0] bits);
        bits = '0;
        @(negedge sout);
        repeat (8) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (16) @(posedge clk);
            bits[i] = sout;
        end
    endtask

    // drive whole frames, then return the line to marking
    task automatic send(input logic [23:0] f, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            sin <= f[i];
            repeat (16) @(posedge clk);
        end
        sin <= 1'b1;
    endtask
endmodule

// ### testbench/uart_line_format_control_test.sv
// self-checking bench for the line format control block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module uart_line_format_control_test;
    import ulfc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        sin;
    logic        sout;
    logic        ir_out_n;
    logic        busy;
    int          bad_count = 0;
    int          compares = 0;
    int          hi;
    int          lo;

    ulfc_line_ctrl uut (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sin(sin),
        .sout(sout), .ir_out_n(ir_out_n), .busy(busy));
    ulfc_remote_model far (.clk(clk), .sout(sout), .sin(sin));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask

    task automatic wait_idle;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
        `CHK(busy, 1'b0)
    endtask

    // count output high and infrared low over 32 cycles
    task automatic cnt(output int h, output int l);
        h = 0;
        l = 0;
        repeat (2) @(posedge clk);
        repeat (32) begin
            @(posedge clk);
            #1 h += (sout === 1'b1);
            l += (ir_out_n === 1'b0);
        end
    endtask

    task automatic t_regs;
        rd_chk(8'h0C, 32'h0);
        wr_reg(8'h0C, 32'hFFFF_FFFF);
        rd_chk(8'h0C, 32'h0000_00DF);
        wr_reg(8'h0C, 32'h0000_0080);
        wr_reg(8'h00, 32'h0000_0001);
        wr_reg(8'h04, 32'h0000_0000);
        rd_chk(8'h00, 32'h0000_0001);
        wr_reg(8'h0C, 32'h0000_0003);
        rd_chk(8'h04, 32'h0);
    endtask

    task automatic t_tx;
        logic [7:0] lc [5] = '{8'h00, 8'h04, 8'h0F, 8'h1A, 8'h05};
        logic [9:0] got;
        logic [7:0] m;
        int         n;
        int         stop;
        int         c;
        for (int k = 0; k < 5; k++) begin
            n = 5 + int'(lc[k][1:0]);
            m = 8'hFF >> (8 - n);
            stop = !lc[k][2] ? 16 : (n == 5 ? 24 : 32);
            wr_reg(8'h0C, {24'h0, lc[k]});
            wr_reg(8'h00, 32'h0000_00B6);
            far.grab(n + int'(lc[k][3]), got);
            `CHK(got[7:0] & m, 8'hB6 & m)
            if (lc[k][3])
                `CHK(got[n], (^(8'hB6 & m)) ^ ~lc[k][4])
            for (c = 0; c < 300 && busy !== 1'b0; c++) @(posedge clk);
            `CHK(c >= stop + 5 && c <= stop + 12, 1'b1)
        end
    endtask

    task automatic t_lock;
        wr_reg(8'h0C, 32'h03);
        wr_reg(8'h00, 32'h11);
        wr_reg(8'h0C, 32'h5C);
        #1 `CHK(busy, 1'b1)
        rd_chk(8'h0C, 32'h43);
        wr_reg(8'h0C, 32'h03);
        wait_idle;
        wr_reg(8'h0C, 32'h1A);
        rd_chk(8'h0C, 32'h1A);
    endtask

    task automatic t_rx;
        wr_reg(8'h0C, 32'h1F);
        far.send({1'b1, 1'b0, 8'h5A, 1'b0}, 11);
        repeat (4) @(posedge clk);
        rd_chk(8'h1C, 32'h12);
        rd_chk(8'h00, 32'h5A);
        far.send({1'b1, 1'b0, 8'h3C, 1'b0, 1'b1, 1'b1, 8'h5A, 1'b0}, 22);
        repeat (4) @(posedge clk);
        rd_chk(8'h1C, 32'h16);
        rd_chk(8'h00, 32'h3C);
    endtask

    task automatic t_break;
        wr_reg(8'h0C, 32'h43);
        cnt(hi, lo);
        `CHK(hi, 0)
        wr_reg(8'h10, 32'h40);
        cnt(hi, lo);
        `CHK(lo, 6)
        `CHK(hi, 0)
        wr_reg(8'h10, 32'h50);
        cnt(hi, lo);
        `CHK(hi, 32)
        `CHK(lo, 32)
        // let one whole looped break character land before clearing
        repeat (150) @(posedge clk);
        rd_chk(8'h00, 32'h0);
        wr_reg(8'h0C, 32'h03);
        wait_idle;
        rd_chk(8'h1C, 32'h1A);
        wr_reg(8'h00, 32'hA5);
        wait_idle;
        rd_chk(8'h00, 32'hA5);
    endtask

    task automatic wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        wrap_up;
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_tx;
        t_lock;
        t_rx;
        t_break;
        wrap_up;
    end
endmodule
